// [rtl/plc_alu_consts.svh]
// Register map, field positions, reset values and step counts
`ifndef PLC_ALU_CONSTS_SVH
`define PLC_ALU_CONSTS_SVH
`define ADDR_CTRL      8'h00
`define ADDR_OPA       8'h04
`define ADDR_OPB       8'h08
`define ADDR_RESULT    8'h0c
`define ADDR_STATUS    8'h10
`define ADDR_MASK      8'h14
`define CTRL_OP_LSB    0
`define CTRL_OP_MSB    3
`define CTRL_GUARD     4
`define CTRL_INVERT    5
`define CTRL_SRC_BCD   6
`define CTRL_DST_BCD   7
`define CTRL_WID_LSB   8
`define CTRL_WID_MSB   11
`define CTRL_DST_REG   12
`define CTRL_START     31
`define ST_BUSY        0
`define ST_DONE        1
`define ST_ZERO        2
`define ST_FAULT       3
`define ST_BADDST      4
`define CTRL_RESET     32'h00001000
`define MASK_RESET     32'hffffffff
`define FULL_GROUPS    4'h8
`define DABBLE_STEPS   6'h20
`define BCD_DIGITS     6'h08
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// [rtl/plc_alu_pkg.sv]
// Types of the arithmetic and logic unit
package plc_alu_pkg;
  typedef enum logic [3:0] {
    resource_move         = 4'h0,
    bitwise_complement    = 4'h1,
    sign_change           = 4'h2,
    add_op                = 4'h3,
    subtract_op           = 4'h4,
    multiply_op           = 4'h5,
    divide_op             = 4'h6,
    remainder_op          = 4'h7,
    and_op                = 4'h8,
    or_op                 = 4'h9,
    xor_op                = 4'ha,
    shift_left_fill_zero  = 4'hb,
    shift_right_fill_zero = 4'hc,
    rotate_left_circular  = 4'hd,
    rotate_right_circular = 4'he
  } alu_op_e;

  typedef enum logic [2:0] {
    st_idle    = 3'h0,
    st_bin2bcd = 3'h1,
    st_bcd2bin = 3'h2,
    st_shift   = 3'h3,
    st_finish  = 3'h4
  } unit_state_e;

  typedef struct packed {
    logic [7:0]  aw_addr;
    logic        aw_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_got;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] result;
    logic [31:0] mask;
    unit_state_e fsm;
    alu_op_e     op;
    logic        dst_reg;
    logic [5:0]  cnt;
    logic [39:0] acc;
    logic [31:0] work;
    logic        done;
    logic        zero;
    logic        fault;
    logic        baddst;
    logic        wr_pulse;
  } unit_state_s;
endpackage : plc_alu_pkg

// [rtl/plc_arith_logic_unit.sv]
// Arithmetic and logic action unit with an AXI4-Lite register port
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`include "plc_alu_consts.svh"
module plc_arith_logic_unit (
  input  wire logic        mclk_in,              // 200 MHz clock
  input  wire logic        rst_in,               // Async reset, high
  input  wire logic [7:0]  s_axi_awaddr_in,      // Write address
  input  wire logic        s_axi_awvalid_in,     // Write address valid
  output      logic        s_axi_awready_out,    // Write address ready
  input  wire logic [31:0] s_axi_wdata_in,       // Write data
  input  wire logic [3:0]  s_axi_wstrb_in,       // Byte strobes
  input  wire logic        s_axi_wvalid_in,      // Write data valid
  output      logic        s_axi_wready_out,     // Write data ready
  output      logic [1:0]  s_axi_bresp_out,      // Write response
  output      logic        s_axi_bvalid_out,     // Write resp valid
  input  wire logic        s_axi_bready_in,      // Write resp ready
  input  wire logic [7:0]  s_axi_araddr_in,      // Read address
  input  wire logic        s_axi_arvalid_in,     // Read address valid
  output      logic        s_axi_arready_out,    // Read address ready
  output      logic [31:0] s_axi_rdata_out,      // Read data
  output      logic [1:0]  s_axi_rresp_out,      // Read response
  output      logic        s_axi_rvalid_out,     // Read data valid
  input  wire logic        s_axi_rready_in,      // Read data ready
  output      logic        result_write_out,     // Result write pulse
  output      logic [31:0] result_data_out,      // Result value
  output      logic [31:0] result_mask_out,      // Bits to write
  output      logic        result_to_reg_out,    // Target is register
  output      logic        halt_out,             // Program halted
  output      logic        zero_result_flag_out  // Bitwise zero flag
);
  import plc_alu_pkg::*;

  plc_alu_pkg::unit_state_s s;
  plc_alu_pkg::unit_state_s next_s;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction : merge_bytes

  // Handshake readies straight from the held state
  assign s_axi_awready_out    = !s.aw_got && !s.bvalid;
  assign s_axi_wready_out     = !s.w_got && !s.bvalid;
  assign s_axi_arready_out    = !s.rvalid;
  assign s_axi_bresp_out      = s.bresp;
  assign s_axi_bvalid_out     = s.bvalid;
  assign s_axi_rdata_out      = s.rdata;
  assign s_axi_rresp_out      = s.rresp;
  assign s_axi_rvalid_out     = s.rvalid;
  assign result_write_out     = s.wr_pulse;
  assign result_data_out      = s.result;
  assign result_mask_out      = s.mask;
  assign result_to_reg_out    = s.dst_reg;
  assign halt_out             = s.fault;
  assign zero_result_flag_out = s.zero;

  // Whole next state: bus slave, then the execution engine
  always_comb
  begin
    logic        start;
    logic [31:0] w1c;
    logic [31:0] cfg;
    logic [31:0] status;
    logic        exec;
    logic [3:0]  groups;
    logic [31:0] wmask;
    logic [31:0] srcv;
    logic [39:0] adj;
    logic        arith;
    start  = 1'b0;
    w1c    = 32'h00000000;
    cfg    = s.ctrl;
    status = 32'h00000000;
    exec   = 1'b0;
    groups = `FULL_GROUPS;
    wmask  = `MASK_RESET;
    srcv   = 32'h00000000;
    adj    = 40'h0000000000;
    arith  = 1'b0;
    next_s = s;
    next_s.wr_pulse = 1'b0;

    // Address and data channels are taken independently
    if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      next_s.aw_addr = s_axi_awaddr_in;
      next_s.aw_got  = 1'b1;
    end
    if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      next_s.w_data = s_axi_wdata_in;
      next_s.w_strb = s_axi_wstrb_in;
      next_s.w_got  = 1'b1;
    end
    if (s.bvalid && s_axi_bready_in)
      next_s.bvalid = 1'b0;
    if (s.rvalid && s_axi_rready_in)
      next_s.rvalid = 1'b0;

    // Register write once both halves are held
    if (s.aw_got && s.w_got && !s.bvalid)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = `RESP_OKAY;
      case (s.aw_addr)
        `ADDR_CTRL:
        begin
          cfg = merge_bytes(s.ctrl, s.w_data, s.w_strb);
          start = cfg[`CTRL_START] && s.w_strb[3];
          cfg[`CTRL_START] = 1'b0;
          next_s.ctrl = cfg;
        end
        `ADDR_OPA:
          next_s.opa = merge_bytes(s.opa, s.w_data, s.w_strb);
        `ADDR_OPB:
          next_s.opb = merge_bytes(s.opb, s.w_data, s.w_strb);
        `ADDR_STATUS:
          w1c = merge_bytes(32'h00000000, s.w_data, s.w_strb);
        `ADDR_RESULT, `ADDR_MASK:
          next_s.bresp = `RESP_OKAY;
        default:
          next_s.bresp = `RESP_SLVERR;
      endcase
    end

    // Status word; busy means an instruction is in flight
    status[`ST_BUSY]   = (s.fsm != st_idle);
    status[`ST_DONE]   = s.done;
    status[`ST_ZERO]   = s.zero;
    status[`ST_FAULT]  = s.fault;
    status[`ST_BADDST] = s.baddst;

    // Register read, answered one cycle after the address
    if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = `RESP_OKAY;
      case (s_axi_araddr_in)
        `ADDR_CTRL:   next_s.rdata = s.ctrl;
        `ADDR_OPA:    next_s.rdata = s.opa;
        `ADDR_OPB:    next_s.rdata = s.opb;
        `ADDR_RESULT: next_s.rdata = s.result;
        `ADDR_STATUS: next_s.rdata = status;
        `ADDR_MASK:   next_s.rdata = s.mask;
        default:
        begin
          next_s.rdata = 32'h00000000;
          next_s.rresp = `RESP_SLVERR;
        end
      endcase
    end

    // Clears first, so an event in the same cycle still sets
    if (w1c[`ST_DONE])
      next_s.done = 1'b0;
    if (w1c[`ST_FAULT])
      next_s.fault = 1'b0;
    if (w1c[`ST_BADDST])
      next_s.baddst = 1'b0;

    // Width in nibble groups; code zero selects full width
    groups = cfg[`CTRL_WID_MSB:`CTRL_WID_LSB];
    if (groups == 4'h0 || groups > `FULL_GROUPS)
      groups = `FULL_GROUPS;
    wmask = `MASK_RESET >> (6'h20 - {groups, 2'h0});
    srcv  = s.opa & wmask;
    exec  = cfg[`CTRL_GUARD] ^ cfg[`CTRL_INVERT];

    // Execution engine
    case (s.fsm)
      st_idle:
      begin
        // A start while halted is dropped; one op at a time
        if (start && !s.fault)
        begin
          next_s.op      = alu_op_e'(cfg[`CTRL_OP_MSB:`CTRL_OP_LSB]);
          next_s.dst_reg = cfg[`CTRL_DST_REG];
          next_s.mask    = `MASK_RESET;
          next_s.fsm     = st_finish;
          next_s.work    = s.opa;
          if (!exec)
          begin
            next_s.done = 1'b1;
            next_s.fsm  = st_idle;
          end
          else
          begin
            case (alu_op_e'(cfg[`CTRL_OP_MSB:`CTRL_OP_LSB]))
              resource_move:
              begin
                next_s.mask = wmask;
                next_s.work = srcv;
                next_s.acc  = 40'h0000000000;
                if (cfg[`CTRL_SRC_BCD] != cfg[`CTRL_DST_BCD])
                begin
                  if (cfg[`CTRL_SRC_BCD])
                  begin
                    next_s.cnt = `BCD_DIGITS;
                    next_s.fsm = st_bcd2bin;
                  end
                  else
                  begin
                    next_s.cnt = `DABBLE_STEPS;
                    next_s.fsm = st_bin2bcd;
                  end
                end
              end
              bitwise_complement:
                next_s.work = ~s.opa;
              sign_change:
                next_s.work = 32'h00000000 - s.opa;
              add_op:
                next_s.work = s.opa + s.opb;
              subtract_op:
                next_s.work = s.opa - s.opb;
              multiply_op:
                next_s.work = 32'(s.opa * s.opb);
              divide_op, remainder_op:
              begin
                if (s.opb == 32'h00000000)
                begin
                  next_s.fault = 1'b1;
                  next_s.done  = 1'b1;
                  next_s.fsm   = st_idle;
                end
                else if (cfg[`CTRL_OP_LSB])
                  next_s.work = $signed(s.opa) % $signed(s.opb);
                else
                  next_s.work = $signed(s.opa) / $signed(s.opb);
              end
              // Immediates arrive already in operand words
              and_op:
                next_s.work = s.opa & s.opb;
              or_op:
                next_s.work = s.opa | s.opb;
              xor_op:
                next_s.work = s.opa ^ s.opb;
              shift_left_fill_zero, shift_right_fill_zero,
              rotate_left_circular, rotate_right_circular:
              begin
                next_s.cnt = {1'b0, s.opb[4:0]};
                next_s.fsm = st_shift;
              end
              default:
              begin
                next_s.done = 1'b1;
                next_s.fsm  = st_idle;
              end
            endcase
          end
        end
      end

      // Double dabble; upper digits fall off through the mask
      st_bin2bcd:
      begin
        adj = s.acc;
        for (int d = 0; d < 10; d++)
        begin
          if (adj[d*4 +: 4] > 4'h4)
            adj[d*4 +: 4] = adj[d*4 +: 4] + 4'h3;
        end
        next_s.acc  = {adj[38:0], s.work[31]};
        next_s.work = {s.work[30:0], 1'b0};
        next_s.cnt  = s.cnt - 6'h01;
        if (s.cnt == 6'h01)
        begin
          next_s.work = next_s.acc[31:0] & s.mask;
          next_s.fsm  = st_finish;
        end
      end

      // Decimal digits from the top, times ten plus digit
      st_bcd2bin:
      begin
        next_s.acc = (s.acc << 3) + (s.acc << 1)
                   + {36'h000000000, s.work[31:28]};
        next_s.work = {s.work[27:0], 4'h0};
        next_s.cnt  = s.cnt - 6'h01;
        if (s.cnt == 6'h01)
        begin
          next_s.work = next_s.acc[31:0] & s.mask;
          next_s.fsm  = st_finish;
        end
      end

      // One bit per cycle; slower but keeps the shifter tiny
      st_shift:
      begin
        if (s.cnt == 6'h00)
          next_s.fsm = st_finish;
        else
        begin
          next_s.cnt = s.cnt - 6'h01;
          case (s.op)
            shift_left_fill_zero:
              next_s.work = {s.work[30:0], 1'b0};
            shift_right_fill_zero:
              next_s.work = {1'b0, s.work[31:1]};
            rotate_left_circular:
              next_s.work = {s.work[30:0], s.work[31]};
            default:
              next_s.work = {s.work[0], s.work[31:1]};
          endcase
        end
      end

      // Deliver result; only moves may target bit resources
      st_finish:
      begin
        arith = (s.op != resource_move);
        next_s.done = 1'b1;
        next_s.fsm  = st_idle;
        if (arith && !s.dst_reg)
          next_s.baddst = 1'b1;
        else
        begin
          next_s.result   = s.work;
          next_s.wr_pulse = 1'b1;
          if (s.op == and_op || s.op == or_op || s.op == xor_op)
            next_s.zero = (s.work == 32'h00000000);
        end
      end

      default:
        next_s.fsm = st_idle;
    endcase
  end

  // State register; reset loads constants only
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s      <= '0;
      s.ctrl <= `CTRL_RESET;
      s.mask <= `MASK_RESET;
      s.fsm  <= st_idle;
      s.op   <= resource_move;
    end
    else
      s <= next_s;
  end
endmodule : plc_arith_logic_unit

// [tb/plc_alu_chk.sv]
// Port-level assertions for the arithmetic and logic unit
`timescale 1ns/100ps
module plc_alu_chk (
  input wire logic        mclk_in,           // Clock
  input wire logic        rst_in,            // Reset
  input wire logic        s_axi_awvalid_in,  // AW valid
  input wire logic        s_axi_awready_out, // AW ready
  input wire logic        s_axi_wvalid_in,   // W valid
  input wire logic        s_axi_wready_out,  // W ready
  input wire logic        s_axi_bvalid_out,  // B valid
  input wire logic        s_axi_bready_in,   // B ready
  input wire logic [1:0]  s_axi_bresp_out,   // B response
  input wire logic        s_axi_arvalid_in,  // AR valid
  input wire logic        s_axi_arready_out, // AR ready
  input wire logic        s_axi_rvalid_out,  // R valid
  input wire logic        s_axi_rready_in,   // R ready
  input wire logic [31:0] s_axi_rdata_out,   // R data
  input wire logic        result_write_out,  // Result pulse
  input wire logic [31:0] result_data_out,   // Result value
  input wire logic [31:0] result_mask_out,   // Result mask
  input wire logic        halt_out           // Halted
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  // Handshake steps of the register port
  sequence wr_taken;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
      && s_axi_wready_out;
  endsequence
  sequence rd_taken;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  a_write_answer:
    assert property (wr_taken |-> ##[1:2] s_axi_bvalid_out)
    else $error("write response missing");
  a_read_answer:
    assert property (rd_taken |=> s_axi_rvalid_out)
    else $error("read response missing");
  a_bresp_hold:
    assert property (s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  a_rdata_hold:
    assert property (s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
  a_write_refused:
    assert property (s_axi_bvalid_out |-> !s_axi_awready_out
      && !s_axi_wready_out)
    else $error("write taken during response");
  a_pulse_single:
    assert property (result_write_out |=> !result_write_out)
    else $error("result pulse too long");
  a_halt_quiet:
    assert property (halt_out |-> !result_write_out)
    else $error("result written while halted");
  a_mask_nibble:
    assert property (result_write_out |-> result_mask_out[3:0] == 4'hf
      && (result_mask_out & (result_mask_out + 32'h1)) == 32'h0)
    else $error("mask not a nibble width");
  a_data_masked:
    assert property (result_write_out
      |-> (result_data_out & ~result_mask_out) == 32'h0)
    else $error("result wider than mask");
  a_mask_steady:
    assert property (result_write_out |-> $stable(result_mask_out))
    else $error("mask moved at pulse");
endmodule : plc_alu_chk

// [tb/result_sink.sv]
// Far-side model: target register written by the unit
`timescale 1ns/100ps
module result_sink (
  input wire logic        mclk_in,   // Clock
  input wire logic        rst_in,    // Async reset, high
  input wire logic        wr_in,     // Result write pulse
  input wire logic [31:0] data_in,   // Result value
  input wire logic [31:0] mask_in,   // Bits to write
  input wire logic        to_reg_in  // Target is a register
);
  logic [31:0] image;  // Register contents
  int          writes; // Pulses seen
  // Masked merge; a pulse to a bit target is only counted, not stored
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      image  <= 32'h0;
      writes <= 0;
    end
    else if (wr_in)
    begin
      if (to_reg_in)
        image <= (image & ~mask_in) | (data_in & mask_in);
      writes <= writes + 1;
    end
  end
endmodule : result_sink

// [tb/tb_top.sv]
// Self-checking bench for the arithmetic and logic unit
`timescale 1ns/100ps
`include "plc_alu_consts.svh"
module tb_top;
  import plc_alu_pkg::*;
  localparam logic [31:0] go = 32'h80001010; // Start, guard, to register
  logic        mclk_in, rst_in;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, result_data_out;
  logic [31:0] result_mask_out, d;
  logic [3:0]  s_axi_wstrb_in;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, r;
  logic        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
  logic        s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
  logic        s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out;
  logic        s_axi_rready_in, result_write_out, result_to_reg_out;
  logic        halt_out, zero_result_flag_out;
  int          n_errors, comparisons, cycles;

  plc_arith_logic_unit DUT (.*);
  result_sink sink (.mclk_in, .rst_in, .wr_in(result_write_out),
    .data_in(result_data_out), .mask_in(result_mask_out),
    .to_reg_in(result_to_reg_out));

  // Clock and hang guard
  initial
  begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      wrap_up;
    end
  end

  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Write; response ready held back one cycle to stall the slave
  task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] q);
    s_axi_awaddr_in  <= a;
    s_axi_wdata_in   <= v;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in  <= 1'b1;
    forever
    begin
      @(posedge mclk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      if (s_axi_bvalid_out && s_axi_bready_in)
      begin
        q = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
        break;
      end
      if (s_axi_bvalid_out) s_axi_bready_in <= 1'b1;
    end
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] q);
    s_axi_araddr_in  <= a;
    s_axi_arvalid_in <= 1'b1;
    forever
    begin
      @(posedge mclk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      if (s_axi_rvalid_out && s_axi_rready_in)
      begin
        v = s_axi_rdata_out;
        q = s_axi_rresp_out;
        s_axi_rready_in <= 1'b0;
        break;
      end
      if (s_axi_rvalid_out) s_axi_rready_in <= 1'b1;
    end
  endtask : rd

  task rc(input logic [7:0] a, input string n, input logic [31:0] e);
    rd(a, d, r);
    chk(n, e, d);
  endtask : rc

  // One instruction: operands, start, wait idle, check, clear done
  task run(input string n, input logic [31:0] c, a, b, e, input int nw);
    int w0;
    w0 = sink.writes;
    wr(`ADDR_OPA, a, r);
    wr(`ADDR_OPB, b, r);
    wr(`ADDR_CTRL, c, r);
    repeat (200)
    begin
      rd(`ADDR_STATUS, d, r);
      if (d[`ST_BUSY] === 1'b0) break;
    end
    chk("busy", 32'h0, 32'(d[`ST_BUSY]));
    if (nw != 0)
    begin
      rc(`ADDR_RESULT, n, e);
      chk(n, e, sink.image & result_mask_out);
    end
    chk("writes", 32'(nw), 32'(sink.writes - w0));
    wr(`ADDR_STATUS, 32'h12, r);
    $display("test %s done", n);
  endtask : run

  initial
  begin
    rst_in = 1'b1;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in} = 3'h0;
    {s_axi_bready_in, s_axi_rready_in} = 2'h0;
    s_axi_awaddr_in = 8'h0;
    s_axi_araddr_in = 8'h0;
    s_axi_wdata_in = 32'h0;
    s_axi_wstrb_in = 4'hf;
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    // Reset values and unmapped places
    rc(`ADDR_CTRL, "ctrl", 32'h00001000);
    rc(`ADDR_MASK, "mask", 32'hffffffff);
    rc(`ADDR_RESULT, "result", 32'h0);
    rc(`ADDR_STATUS, "status", 32'h0);
    wr(8'h18, 32'h1, r);
    chk("bresp", 32'h2, 32'(r));
    rd(8'h1c, d, r);
    chk("rresp", 32'h2, 32'(r));
    chk("rdata", 32'h0, d);
    // Byte lanes: only the strobed lane moves
    wr(`ADDR_OPA, 32'h11223344, r);
    s_axi_wstrb_in <= 4'h2;
    wr(`ADDR_OPA, 32'hffffabff, r);
    s_axi_wstrb_in <= 4'hf;
    rc(`ADDR_OPA, "strobe", 32'h1122ab44);
    // Arithmetic
    run("add", go | 32'(add_op), 32'h4d2, 32'h64,
      32'h536, 1);
    run("sub", go | 32'(subtract_op), 32'h4d2, 32'h64,
      32'h46e, 1);
    run("mul", go | 32'(multiply_op), 32'h4d2, 32'h64,
      32'h1e208, 1);
    run("div", go | 32'(divide_op), 32'h4d2, 32'h64,
      32'hc, 1);
    run("rem", go | 32'(remainder_op), 32'h223d, 32'h3e8,
      32'h2fd, 1);
    run("wrap", go | 32'(add_op), 32'h7fffffff, 32'h1,
      32'h80000000, 1);
    run("neg", go | 32'(multiply_op), 32'hffffffff, 32'h2,
      32'hfffffffe, 1);
    run("sdiv", go | 32'(divide_op), 32'hfffffff9, 32'h2,
      32'hfffffffd, 1);
    run("cpl", go | 32'(bitwise_complement), 32'h11111111, 32'h0,
      32'heeeeeeee, 1);
    run("sgn", go | 32'(sign_change), 32'h11111111, 32'h0,
      32'heeeeeeef, 1);
    // Bitwise with zero flag
    run("and", go | 32'(and_op), 32'h92, 32'h45, 32'h0, 1);
    chk("zero", 32'h1, 32'(zero_result_flag_out));
    run("or", go | 32'(or_op), 32'h92, 32'h45, 32'hd7, 1);
    chk("zero", 32'h0, 32'(zero_result_flag_out));
    run("xor", go | 32'(xor_op), 32'ha, 32'he, 32'h4, 1);
    run("andi", go | 32'(and_op), 32'hf, 32'h45, 32'h5, 1);
    // Shifts and rotates, counts at both ends
    run("shl", go | 32'(shift_left_fill_zero), 32'h80000001, 32'h1,
      32'h2, 1);
    run("shr", go | 32'(shift_right_fill_zero), 32'h80000001, 32'h1f,
      32'h1, 1);
    run("sh0", go | 32'(shift_left_fill_zero), 32'h1234, 32'h0,
      32'h1234, 1);
    run("rol", go | 32'(rotate_left_circular), 32'h30cc46d4, 32'h4,
      32'h0cc46d43, 1);
    run("ror", go | 32'(rotate_right_circular), 32'h1, 32'h1,
      32'h80000000, 1);
    // Moves: widths and codes
    run("mv32", go, 32'h89abcdef, 32'h0, 32'h89abcdef, 1);
    run("mv12", go | 32'h300, 32'habcdef, 32'h0, 32'hdef, 1);
    rc(`ADDR_MASK, "mask12", 32'hfff);
    // Only the low byte (210) moves; its hundreds digit is lost
    run("bcd8", go | 32'h280, 32'h4d2, 32'h0, 32'h10, 1);
    run("bcd32", go | 32'h880, 32'h5f5e0ff, 32'h0,
      32'h99999999, 1);
    run("bcd4", go | 32'h180, 32'h9, 32'h0, 32'h9, 1);
    run("bin20", go | 32'h540, 32'h12345, 32'h0, 32'h3039, 1);
    run("bcdcp", go | 32'h3c0, 32'h123456, 32'h0, 32'h456, 1);
    // Guard, destination and divide fault
    run("noguard", 32'h80001003, 32'h1, 32'h1, 32'h0, 0);
    run("inv", 32'h80001023, 32'h4d2, 32'h64, 32'h536, 1);
    run("invoff", 32'h80001033, 32'h1, 32'h1, 32'h0, 0);
    run("baddst", 32'h80000013, 32'h1, 32'h1, 32'h0, 0);
    // Same refused target again; done and bad-target must both show
    wr(`ADDR_CTRL, 32'h80000013, r);
    rc(`ADDR_STATUS, "baddst", 32'h12);
    wr(`ADDR_STATUS, 32'h12, r);
    run("nop", go | 32'hf, 32'h1, 32'h1, 32'h0, 0);
    run("div0", go | 32'(divide_op), 32'h4d2, 32'h0, 32'h0, 0);
    chk("halt", 32'h1, 32'(halt_out));
    run("halted", go | 32'(add_op), 32'h1, 32'h1, 32'h0, 0);
    wr(`ADDR_STATUS, 32'h8, r);
    chk("halt", 32'h0, 32'(halt_out));
    wrap_up;
  end
endmodule : tb_top

bind plc_arith_logic_unit plc_alu_chk chk (.*);
